// file: hdl/sdpi_core.sv
// Device-side pin command interface of a four-bank synchronous DRAM.
// Assumes all pins synchronous to clock_i; the controller keeps timing legal.
// Functional notes
// - Clock gate high runs internal clocking; low enters power-down, suspend or self-refresh.
// - Row, column and write strobe levels at the rising edge form the command.
// - Activate captures all thirteen address bits as the row.
// - Column uses low address bits: x4 to bit 11 skipping 10, x8 9, x16 8.
// - Address bit 10 high on a read, or on a write while the queue has room, requests auto close after burst.
// - Auto close shuts the bank named by that command's bank select.
// - Precharge with bit 10 high closes all four banks.
// - Precharge with bit 10 low closes only the selected bank.
// - Bank select inputs pick the bank a bank-directed command acts on.
// - Mask sampled high puts the data buffers in high impedance.
// - Read mask acts as output enable two cycles later.
// - Write mask acts at once: low writes, high discards the word.
// - x4 and x8 have one mask; x16 masks low and high bytes apart.
// - Encoding: activate LHH, read HLH, write HLL, precharge LHL, refresh LLH, etc.
// - Clock gate level one edge before a command against now decides entry or exit.
`timescale 1ns/100ps
module sdpi_core
   import sdpi_pkg::*;
#(
   parameter int ORG = ORG_X8,
   parameter int DW = ORG,
   parameter int NMASK = (ORG == ORG_X16) ? 2 : 1
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic cke_i,
   input wire logic sel_n_i,
   input wire logic row_strobe_n_i,
   input wire logic col_strobe_n_i,
   input wire logic wr_strobe_n_i,
   input wire logic [ADDR_W-1:0] addr_bus_i,
   input wire logic bank_sel_lo_i,
   input wire logic bank_sel_hi_i,
   input wire logic [NMASK-1:0] data_mask_i,
   input wire logic [DW-1:0] data_io_i,
   output logic [DW-1:0] data_io_o,
   output logic [NMASK-1:0] data_io_oe_o,
   output logic [NUM_BANKS-1:0] bank_open_o,
   output logic [ADDR_W-1:0] last_row_o,
   output logic [3:0] pwr_state_o,
   output logic wr_busy_o
);
   localparam int COLW = (ORG == ORG_X4) ? COL_W_X4 : (ORG == ORG_X8) ? COL_W_X8 : COL_W_X16;
   localparam int CIDX = MEM_AW - BANK_W;
   localparam int RQW = $bits(sdpi_wr_req_t);

   sdpi_pwr_t state_r;
   logic cke_prev_r;
   logic [NUM_BANKS-1:0] bank_open_r;
   logic [ADDR_W-1:0] row_r [NUM_BANKS];
   logic [ADDR_W-1:0] last_row_r;
   logic auto_close_pend_r;
   logic [BANK_W-1:0] auto_close_bank_r;
   logic rd_p1_r;
   logic [NMASK-1:0] mask_d1_r;
   logic [DW-1:0] data_out_r;
   logic [NMASK-1:0] oe_r;
   logic wr_busy_r;

   sdpi_cmd_t cmd;
   logic [BANK_W-1:0] bank;
   logic cmd_en;
   logic is_act;
   logic is_rd;
   logic is_wr;
   logic is_pre;
   logic is_self;
   logic auto_close_bit;
   logic [COLW-1:0] col;
   logic [MEM_AW-1:0] mem_addr;
   sdpi_wr_req_t req;
   sdpi_wr_req_t drain_req;
   logic [RQW-1:0] drain_bits;
   logic push;
   logic fifo_ready;
   logic drain_valid;
   logic drain_ready;
   logic [MEM_AW-1:0] mem_port_addr;
   logic [NMASK-1:0] mem_we;
   logic [DW-1:0] mem_rdata;

   // Column address from the low address bits
   function automatic logic [COLW-1:0] col_of(input logic [ADDR_W-1:0] a);
      logic [COL_W_X4-1:0] c4;
      c4 = {a[X4_COL_TOP_POS], a[AUTO_CLOSE_POS-1:0]};
      if (ORG == ORG_X4) begin
         col_of = COLW'(c4);
      end else begin
         col_of = a[COLW-1:0];
      end
   endfunction

   assign cmd = '{row_n: row_strobe_n_i, col_n: col_strobe_n_i, wr_n: wr_strobe_n_i};
   assign bank = {bank_sel_hi_i, bank_sel_lo_i};
   assign cmd_en = cke_prev_r && (state_r == PWR_RUN) && !sel_n_i;
   assign is_act = cmd_en && (cmd == CMD_ACTIVATE);
   assign is_rd = cmd_en && (cmd == CMD_READ);
   assign is_wr = cmd_en && (cmd == CMD_WRITE);
   assign is_pre = cmd_en && (cmd == CMD_PRECHARGE);
   assign is_self = cmd_en && (cmd == CMD_REFRESH) && !cke_i;
   assign auto_close_bit = addr_bus_i[AUTO_CLOSE_POS];
   assign col = col_of(addr_bus_i);
   assign mem_addr = {bank, col[CIDX-1:0]};

   // Write word enters the queue per unmasked lane
   always_comb begin
      req = '0;
      req.addr = mem_addr;
      req.data = DATA_MAX_W'(data_io_i);
      req.lane_we = LANE_MAX'(~data_mask_i);
   end
   assign push = is_wr && (data_mask_i != '1);

   sdpi_fifo #(.W(RQW), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(req),
      .out_valid_o(drain_valid),
      .out_ready_i(drain_ready),
      .out_data_o(drain_bits)
   );

   // Reads own the array port; queued writes wait
   assign drain_req = sdpi_wr_req_t'(drain_bits);
   assign drain_ready = !is_rd;
   assign mem_port_addr = is_rd ? mem_addr : drain_req.addr;
   assign mem_we = (drain_valid && drain_ready) ? NMASK'(drain_req.lane_we) : '0;

   sdpi_mem #(.AW(MEM_AW), .DW(DW), .LANES(NMASK)) u_mem (
      .clock_i(clock_i),
      .addr_i(mem_port_addr),
      .lane_we_i(mem_we),
      .wdata_i(drain_req.data[DW-1:0]),
      .rdata_o(mem_rdata)
   );

   // Clock gate history and power state
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // History starts low: no command at the first edge after reset
         cke_prev_r <= 1'b0;
         state_r <= PWR_RUN;
      end else begin
         cke_prev_r <= cke_i;
         if (cke_prev_r && !cke_i && state_r == PWR_RUN) begin
            if (is_self) begin
               state_r <= PWR_SELF_REFRESH;
            end else if (bank_open_r != '0 || auto_close_pend_r || rd_p1_r) begin
               state_r <= PWR_SUSPEND;
            end else begin
               state_r <= PWR_DOWN;
            end
         end else if (!cke_prev_r && cke_i) begin
            state_r <= PWR_RUN;
         end
      end
   end

   // Bank open and close tracking
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bank_open_r <= '0;
         auto_close_pend_r <= 1'b0;
         auto_close_bank_r <= '0;
         last_row_r <= '0;
         for (int b = 0; b < NUM_BANKS; b++) begin
            row_r[b] <= '0;
         end
      end else begin
         // Burst length one: the close lands one edge after the command
         auto_close_pend_r <= (is_rd || (is_wr && fifo_ready)) && auto_close_bit;
         auto_close_bank_r <= bank;
         if (auto_close_pend_r) begin
            bank_open_r[auto_close_bank_r] <= 1'b0;
         end
         if (is_act) begin
            bank_open_r[bank] <= 1'b1;
            row_r[bank] <= addr_bus_i;
            last_row_r <= addr_bus_i;
         end else if (is_pre && auto_close_bit) begin
            bank_open_r <= '0;
         end else if (is_pre) begin
            bank_open_r[bank] <= 1'b0;
         end
      end
   end

   // Read pipeline; mask two edges ahead gates the drivers
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rd_p1_r <= 1'b0;
         mask_d1_r <= '0;
         data_out_r <= '0;
         oe_r <= '0;
      end else begin
         rd_p1_r <= is_rd;
         mask_d1_r <= data_mask_i;
         data_out_r <= mem_rdata;
         oe_r <= rd_p1_r ? ~mask_d1_r : '0;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_busy_r <= 1'b0;
      end else begin
         wr_busy_r <= !fifo_ready;
      end
   end

   assign data_io_o = data_out_r;
   assign data_io_oe_o = oe_r;
   assign bank_open_o = bank_open_r;
   assign last_row_o = last_row_r;
   assign pwr_state_o = state_r;
   assign wr_busy_o = wr_busy_r;

   AST_OE_LATENCY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_rd && data_mask_i == '0 |-> ##2 data_io_oe_o == '1)
      else $error("read output not enabled two cycles after read");
   AST_MASK_HIZ: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_rd && data_mask_i == '1 |-> ##2 data_io_oe_o == '0)
      else $error("masked read word was driven");
   AST_IDLE_NO_DRIVE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !rd_p1_r |=> data_io_oe_o == '0)
      else $error("data driven without a read");
   AST_PRECHARGE_ALL: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_pre && auto_close_bit |=> bank_open_o == '0)
      else $error("precharge all left a bank open");
   AST_PRECHARGE_ONE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_pre && !auto_close_bit && !auto_close_pend_r |=>
      bank_open_o == ($past(bank_open_o) & ~(NUM_BANKS'(1) << $past(bank))))
      else $error("single precharge touched the wrong banks");
   AST_ACTIVATE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_act |=> bank_open_o[$past(bank)] && last_row_o == $past(addr_bus_i))
      else $error("activate did not open bank with row");
   AST_AUTO_CLOSE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_rd && auto_close_bit ##1 !is_act |=> !bank_open_o[$past(bank, 2)])
      else $error("auto close did not shut the addressed bank");
   AST_DESELECT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      sel_n_i && !auto_close_pend_r |=> $stable(bank_open_o))
      else $error("command taken while deselected");
   AST_CKE_ENTRY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cke_prev_r && !cke_i && state_r == PWR_RUN |=> pwr_state_o != PWR_RUN)
      else $error("clock gate low did not stop the device");
   AST_CKE_EXIT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !cke_prev_r && cke_i |=> pwr_state_o == PWR_RUN)
      else $error("clock gate high did not resume");
   AST_WRITE_MASK: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_wr && data_mask_i == '1 && !drain_valid |=> !drain_valid)
      else $error("masked write word was queued");

   // Power state checks
   AST_PWR_ONEHOT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      $onehot(pwr_state_o))
      else $error("power state is not one-hot");
   AST_SELF_ENTRY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_self |=> pwr_state_o == PWR_SELF_REFRESH)
      else $error("refresh with clock gate low did not enter self refresh");
   AST_SUSPEND_ENTRY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cke_prev_r && !cke_i && state_r == PWR_RUN && !is_self && bank_open_r != '0
      |=> pwr_state_o == PWR_SUSPEND)
      else $error("clock gate low with a bank open did not suspend");
   AST_PD_ENTRY: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cke_prev_r && !cke_i && state_r == PWR_RUN && !is_self && bank_open_r == '0
      && !auto_close_pend_r && !rd_p1_r |=> pwr_state_o == PWR_DOWN)
      else $error("clock gate low while idle did not power down");
   AST_ASLEEP_HOLD: assert property (@(posedge clock_i) disable iff (!nrst_i)
      state_r != PWR_RUN && !auto_close_pend_r |=> $stable(bank_open_o))
      else $error("bank state changed while the clock was stopped");

   // Bank and row checks
   AST_ROW_KEPT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_act |=> row_r[$past(bank)] == $past(addr_bus_i))
      else $error("activate did not store the row of its bank");
   AST_OPEN_KEPT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_rd && !auto_close_bit && bank_open_r[bank] && !auto_close_pend_r |=>
      bank_open_o[$past(bank)])
      else $error("read without auto close shut its bank");
   AST_WR_AUTO_CLOSE: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_wr && fifo_ready && auto_close_bit ##1 !is_act |=> !bank_open_o[$past(bank, 2)])
      else $error("write with auto close left its bank open");
   AST_REFRESH_KEEPS: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cmd_en && cmd == CMD_REFRESH && cke_i && !auto_close_pend_r |=> $stable(bank_open_o))
      else $error("refresh changed the bank state");

   // Lane checks
   AST_LANE_SPLIT: assert property (@(posedge clock_i) disable iff (!nrst_i)
      is_rd && data_mask_i[0] != data_mask_i[NMASK-1] |->
      ##2 data_io_oe_o[0] != data_io_oe_o[NMASK-1])
      else $error("byte lane enables did not follow their own masks");

   // Main scenarios
   CVR_READ: cover property (@(posedge clock_i) disable iff (!nrst_i)
      is_rd ##2 data_io_oe_o != '0);
   CVR_WRITE_QUEUED: cover property (@(posedge clock_i) disable iff (!nrst_i)
      push ##1 drain_valid);
   CVR_SELF: cover property (@(posedge clock_i) disable iff (!nrst_i)
      pwr_state_o == PWR_SELF_REFRESH);
   CVR_SUSPEND: cover property (@(posedge clock_i) disable iff (!nrst_i)
      pwr_state_o == PWR_SUSPEND);
   CVR_PDOWN: cover property (@(posedge clock_i) disable iff (!nrst_i)
      pwr_state_o == PWR_DOWN);
endmodule

// file: hdl/sdpi_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes single clock, asynchronous active-low reset.
`timescale 1ns/100ps
module sdpi_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 4
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);

   logic [W-1:0] mem_r [DEPTH];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0] count_r;
   logic push;
   logic pop;

   assign in_ready_o = (count_r != (PW+1)'(DEPTH));
   assign out_valid_o = (count_r != '0);
   assign out_data_o = mem_r[rd_ptr_r];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
   endfunction

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= ptr_inc(wr_ptr_r);
         end
         if (pop) begin
            rd_ptr_r <= ptr_inc(rd_ptr_r);
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

// file: hdl/sdpi_mem.sv
// Single-port storage array with per-lane write enables.
// Read data are registered; a write cycle leaves read data unchanged.
`timescale 1ns/100ps
module sdpi_mem #(
   parameter int AW = 8,
   parameter int DW = 8,
   parameter int LANES = 1
) (
   input wire logic clock_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [LANES-1:0] lane_we_i,
   input wire logic [DW-1:0] wdata_i,
   output logic [DW-1:0] rdata_o
);
   localparam int LW = DW / LANES;

   logic [DW-1:0] store_r [2**AW];

   always_ff @(posedge clock_i) begin
      for (int l = 0; l < LANES; l++) begin
         if (lane_we_i[l]) begin
            store_r[addr_i][l*LW +: LW] <= wdata_i[l*LW +: LW];
         end
      end
      if (lane_we_i == '0) begin
         rdata_o <= store_r[addr_i];
      end
   end
endmodule

// file: hdl/sdpi_pkg.sv
// Shared constants and types of the SDRAM pin command interface.
// Assumes one 100 MHz clock and the device-side view of the pins.
package sdpi_pkg;

   localparam int ADDR_W = 13;
   localparam int BANK_W = 2;
   localparam int NUM_BANKS = 4;
   localparam int AUTO_CLOSE_POS = 10;
   localparam int X4_COL_TOP_POS = 11;
   localparam int COL_W_X4 = 11;
   localparam int COL_W_X8 = 10;
   localparam int COL_W_X16 = 9;
   localparam int ORG_X4 = 4;
   localparam int ORG_X8 = 8;
   localparam int ORG_X16 = 16;
   localparam int DATA_MAX_W = 16;
   localparam int LANE_MAX = 2;
   localparam int MEM_AW = 8;
   localparam int READ_LAT = 2;
   localparam int FIFO_DEPTH = 4;
   localparam real CLK_PERIOD_NS = 10.0;

   // Row, column, write strobe levels in that order
   localparam logic [2:0] CMD_MODE_SET = 3'h0;
   localparam logic [2:0] CMD_REFRESH = 3'h1;
   localparam logic [2:0] CMD_PRECHARGE = 3'h2;
   localparam logic [2:0] CMD_ACTIVATE = 3'h3;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_BURST_STOP = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;

   typedef enum logic [3:0] {
      PWR_RUN = 4'h1,
      PWR_DOWN = 4'h2,
      PWR_SUSPEND = 4'h4,
      PWR_SELF_REFRESH = 4'h8
   } sdpi_pwr_t;

   typedef struct packed {
      logic row_n;
      logic col_n;
      logic wr_n;
   } sdpi_cmd_t;

   typedef struct packed {
      logic [MEM_AW-1:0] addr;
      logic [DATA_MAX_W-1:0] data;
      logic [LANE_MAX-1:0] lane_we;
   } sdpi_wr_req_t;

endpackage

// file: sim/sdpi_bench.sv
// Self-checking bench of the x16 pin command interface.
// Assumes the host model in sdpi_host and a 100 MHz clock.
`timescale 1ns/100ps
module sdram_pin_command_interface_bench
   import sdpi_pkg::*;
;
   typedef struct packed {
      logic [1:0] b;
      logic [5:0] col;
      logic [15:0] wd;
      logic [1:0] wm;
      logic [1:0] rm;
      logic [15:0] rd;
   } sdpi_row_t;

   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic cke;
   logic sel_n;
   sdpi_cmd_t cmd_pins;
   logic [ADDR_W-1:0] addr;
   logic [BANK_W-1:0] bank;
   logic [1:0] mask;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic [1:0] oe;
   logic [3:0] bank_open;
   logic [ADDR_W-1:0] last_row;
   logic [3:0] pwr;
   logic wr_busy;
   int miscompares = 0;
   int checked = 0;
   sdpi_row_t rows [0:6] = '{
      '{2'h0, 6'h01, 16'hA5C3, 2'h0, 2'h0, 16'hA5C3},
      '{2'h0, 6'h01, 16'hFFFF, 2'h1, 2'h0, 16'hFFC3},
      '{2'h0, 6'h01, 16'h0000, 2'h3, 2'h0, 16'hFFC3},
      '{2'h3, 6'h3F, 16'h5A5A, 2'h0, 2'h2, 16'h5A5A},
      '{2'h2, 6'h00, 16'h0F0F, 2'h0, 2'h3, 16'h0F0F},
      '{2'h1, 6'h01, 16'h7E81, 2'h0, 2'h0, 16'h7E81},
      '{2'h0, 6'h01, 16'h0000, 2'h3, 2'h1, 16'hFFC3}};

   always #(CLK_PERIOD_NS / 2) clock = ~clock;

   sdpi_host u_host (.clock_i(clock), .cke_o(cke), .sel_n_o(sel_n), .cmd_o(cmd_pins),
      .addr_o(addr), .bank_o(bank), .mask_o(mask), .data_o(wdata));

   sdpi_core #(.ORG(ORG_X16)) dut (.clock_i(clock), .nrst_i(nrst), .cke_i(cke),
      .sel_n_i(sel_n), .row_strobe_n_i(cmd_pins.row_n), .col_strobe_n_i(cmd_pins.col_n),
      .wr_strobe_n_i(cmd_pins.wr_n), .addr_bus_i(addr), .bank_sel_lo_i(bank[0]),
      .bank_sel_hi_i(bank[1]), .data_mask_i(mask), .data_io_i(wdata), .data_io_o(rdata),
      .data_io_oe_o(oe), .bank_open_o(bank_open), .last_row_o(last_row),
      .pwr_state_o(pwr), .wr_busy_o(wr_busy));

   function automatic logic [15:0] lanes(input logic [1:0] m);
      return {{8{~m[1]}}, {8{~m[0]}}};
   endfunction

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [12:0] a,
         input logic [1:0] m, input logic [15:0] d);
      u_host.drive(1'b0, c, b, a, m, d, 1'b1);
   endtask

   task automatic nop_cke(input logic ce);
      u_host.drive(1'b1, CMD_NOP, 2'h0, 13'h0000, 2'h0, 16'h0000, ce);
   endtask

   task automatic settle();
      u_host.idle();
      #1;
   endtask

   task automatic finish_test();
      if (miscompares == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge clock);
      miscompares++;
      finish_test();
   end

   initial begin
      sdpi_row_t r;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      repeat (2) u_host.idle();
      settle();
      chk("pwr", 16'h0001, {12'h000, pwr});
      for (int i = 0; i < 7; i++) begin
         r = rows[i];
         cmd(CMD_ACTIVATE, r.b, 13'h0123, 2'h0, 16'h0000);
         cmd(CMD_WRITE, r.b, {7'h00, r.col}, r.wm, r.wd);
         repeat (6) u_host.idle();
         cmd(CMD_READ, r.b, {7'h00, r.col}, r.rm, 16'h0000);
         u_host.idle();
         settle();
         chk("oe", {14'h0000, ~r.rm}, {14'h0000, oe});
         chk("rdata", r.rd & lanes(r.rm), rdata & lanes(r.rm));
         @(posedge clock);
         #1;
         chk("oe_end", 16'h0000, {14'h0000, oe});
         chk("busy", 16'h0000, {15'h0000, wr_busy});
      end
      cmd(CMD_ACTIVATE, 2'h2, 13'h1FFF, 2'h0, 16'h0000);
      settle();
      chk("row", 16'h1FFF, {3'h0, last_row});
      cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 16'h0000);
      settle();
      chk("banks_all", 16'h0000, {12'h000, bank_open});
      for (int b = 0; b < 4; b++) begin
         cmd(CMD_ACTIVATE, b[1:0], 13'h0000, 2'h0, 16'h0000);
      end
      settle();
      chk("banks_act", 16'h000F, {12'h000, bank_open});
      cmd(CMD_PRECHARGE, 2'h2, 13'h0000, 2'h0, 16'h0000);
      settle();
      chk("banks_one", 16'h000B, {12'h000, bank_open});
      u_host.drive(1'b1, CMD_ACTIVATE, 2'h2, 13'h0000, 2'h0, 16'h0000, 1'b1);
      settle();
      chk("desel", 16'h000B, {12'h000, bank_open});
      cmd(CMD_MODE_SET, 2'h0, 13'h0000, 2'h0, 16'h0000);
      cmd(CMD_BURST_STOP, 2'h2, 13'h0000, 2'h0, 16'h0000);
      cmd(CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 16'h0000);
      cmd(CMD_NOP, 2'h2, 13'h0400, 2'h0, 16'h0000);
      settle();
      chk("codes", 16'h000B, {12'h000, bank_open});
      cmd(CMD_READ, 2'h1, 13'h0400, 2'h0, 16'h0000);
      settle();
      settle();
      chk("rd_close", 16'h0009, {12'h000, bank_open});
      cmd(CMD_WRITE, 2'h0, 13'h0005, 2'h0, 16'h1111);
      settle();
      settle();
      chk("wr_open", 16'h0009, {12'h000, bank_open});
      cmd(CMD_WRITE, 2'h3, 13'h0405, 2'h0, 16'h2222);
      settle();
      settle();
      chk("wr_close", 16'h0001, {12'h000, bank_open});
      repeat (6) u_host.idle();
      nop_cke(1'b0);
      settle();
      chk("suspend", 16'h0004, {12'h000, pwr});
      nop_cke(1'b1);
      settle();
      chk("resume", 16'h0001, {12'h000, pwr});
      cmd(CMD_PRECHARGE, 2'h0, 13'h0400, 2'h0, 16'h0000);
      nop_cke(1'b0);
      settle();
      chk("pdown", 16'h0002, {12'h000, pwr});
      u_host.drive(1'b0, CMD_ACTIVATE, 2'h1, 13'h0000, 2'h0, 16'h0000, 1'b0);
      settle();
      chk("pd_act", 16'h0000, {12'h000, bank_open});
      nop_cke(1'b1);
      settle();
      chk("pd_exit", 16'h0001, {12'h000, pwr});
      u_host.drive(1'b0, CMD_REFRESH, 2'h0, 13'h0000, 2'h0, 16'h0000, 1'b0);
      settle();
      chk("self_ref", 16'h0008, {12'h000, pwr});
      nop_cke(1'b1);
      settle();
      chk("sr_exit", 16'h0001, {12'h000, pwr});
      cmd(CMD_ACTIVATE, 2'h1, 13'h0042, 2'h0, 16'h0000);
      settle();
      chk("pre_rst", 16'h0002, {12'h000, bank_open});
      nrst <= 1'b0;
      #1;
      chk("rst_banks", 16'h0000, {12'h000, bank_open});
      chk("rst_row", 16'h0000, {3'h0, last_row});
      chk("rst_rdata", 16'h0000, rdata);
      @(posedge clock);
      nrst <= 1'b1;
      cmd(CMD_ACTIVATE, 2'h2, 13'h0007, 2'h0, 16'h0000);
      settle();
      chk("rst_first", 16'h0004, {12'h000, bank_open});
      finish_test();
   end
endmodule

// file: sim/sdpi_host.sv
// Controller model driving the command, address, mask and data pins of the device.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/100ps
module sdpi_host
   import sdpi_pkg::*;
(
   input wire logic clock_i,
   output logic cke_o,
   output logic sel_n_o,
   output sdpi_cmd_t cmd_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [BANK_W-1:0] bank_o,
   output logic [1:0] mask_o,
   output logic [15:0] data_o
);
   initial begin
      cke_o = 1'b1;
      sel_n_o = 1'b1;
      cmd_o = CMD_NOP;
      addr_o = '0;
      bank_o = '0;
      mask_o = '0;
      data_o = '0;
   end

   // One command, launched at an edge and sampled at the next
   task automatic drive(input logic sn, input logic [2:0] c, input logic [1:0] b,
         input logic [12:0] a, input logic [1:0] m, input logic [15:0] d, input logic ce);
      @(posedge clock_i);
      sel_n_o <= sn;
      cmd_o <= c;
      addr_o <= a;
      bank_o <= b;
      mask_o <= m;
      data_o <= d;
      cke_o <= ce;
   endtask

   // Deselected cycle; address and data lines show the inverse of their last value
   task automatic idle();
      @(posedge clock_i);
      sel_n_o <= 1'b1;
      cmd_o <= CMD_NOP;
      addr_o <= ~addr_o;
      mask_o <= '0;
      data_o <= ~data_o;
   endtask
endmodule
